// ### rtl/idl_b_pkg.sv
// constants and arithmetic for the format b framer
// assumes streams start at byte 4, after the framing code
package idl_b_pkg;

    // byte positions within the packet
    localparam logic [5:0] POS_CHANNEL = 6'h04;
    localparam logic [5:0] POS_DESIGNATION = 6'h05;
    localparam logic [5:0] POS_FORMAT = 6'h06;
    localparam logic [5:0] POS_APP_ID = 6'h07;
    localparam logic [5:0] POS_CONTINUITY = 6'h08;
    localparam logic [5:0] POS_DATA_FIRST = 6'h09;
    localparam logic [5:0] POS_DATA_LAST = 6'h2B;
    localparam logic [5:0] POS_SUFFIX0 = 6'h2C;
    localparam logic [5:0] POS_SUFFIX1 = 6'h2D;

    // protection rows of a bundle, user bytes per packet, tracked services
    localparam logic [3:0] CI_PROTECT_P = 4'hE;
    localparam logic [3:0] CI_PROTECT_Q = 4'hF;
    localparam int USER_BYTES = 35;
    localparam int SERVICES = 1024;

    // format type message bits
    localparam int FT_FORMAT_BIT = 0;
    localparam int FT_SECOND_BIT = 1;
    localparam int FT_AN_LOW = 2;
    localparam int FT_AN_HIGH = 3;

    // galois field constants
    localparam logic [7:0] GF_POLY_LOW = 8'h1D;
    localparam logic [7:0] GF_INV_ONE_PLUS_A = 8'hF4;

    typedef enum logic [1:0] {
        format_a,
        format_b,
        format_reserved
    } format_kind_type;

    // hamming 8/4: bit order p1 d1 p2 d2 p3 d3 p4 d4 from bit 0 upward
    function automatic logic [7:0] ham_encode(input logic [3:0] m);
        logic p1, p2, p3, p4;
        p1 = ~(m[0] ^ m[2] ^ m[3]);
        p2 = ~(m[0] ^ m[1] ^ m[3]);
        p3 = ~(m[0] ^ m[1] ^ m[2]);
        p4 = ~(p1 ^ m[0] ^ p2 ^ m[1] ^ p3 ^ m[2] ^ m[3]);
        return {m[3], p4, m[2], p3, m[1], p2, m[0], p1};
    endfunction

    // returns {error, message}
    function automatic logic [4:0] ham_decode(input logic [7:0] b);
        logic ok;
        ok = (b[0] ^ b[1] ^ b[5] ^ b[7]) & (b[2] ^ b[1] ^ b[3] ^ b[7]) & (b[4] ^ b[1] ^ b[3] ^ b[5]) & (^b);
        return {~ok, b[7], b[5], b[3], b[1]};
    endfunction

    // multiply by the primitive element
    function automatic logic [7:0] gf_mul2(input logic [7:0] v);
        return v[7] ? ({v[6:0], 1'b0} ^ GF_POLY_LOW) : {v[6:0], 1'b0};
    endfunction

    // field multiply
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] acc, sh;
        acc = 8'h00;
        sh = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                acc = acc ^ sh;
            end
            sh = gf_mul2(sh);
        end
        return acc;
    endfunction

    // first suffix byte
    function automatic logic [7:0] suffix_first(input logic [7:0] x, input logic [7:0] y);
        return gf_mul(x ^ y, GF_INV_ONE_PLUS_A);
    endfunction

    // service index
    function automatic logic [9:0] service_index(input logic [3:0] ch, input logic [3:0] ai, input logic [1:0] an);
        return {ch, ai, an};
    endfunction

endpackage

// ### rtl/idl_link_if.sv
// byte stream carried between inserter and decoder
// assumes a shared clock; bit 0 goes first
`timescale 1ns/1ps
interface idl_link_if;
    logic [7:0] line_byte;
    logic line_valid;
    logic line_start;

    modport inserter (output line_byte, output line_valid, output line_start);
    modport decoder (input line_byte, input line_valid, input line_start);
endinterface

// ### rtl/idl_b_inserter.sv
// format b packet builder
// assumes payload_byte is ready whenever payload_take is high
`timescale 1ns/1ps
module idl_b_inserter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // user request
    input wire logic pkt_request,
    input wire logic [3:0] req_channel,
    input wire logic [3:0] req_designation,
    input wire logic [3:0] req_app_id,
    input wire logic [1:0] req_app_number,
    input wire logic req_repeat,
    output logic busy,
    // payload supply
    input wire logic [7:0] payload_byte,
    output logic payload_take,
    // link
    idl_link_if.inserter link
);
    import idl_b_pkg::*;

    typedef enum {st_idle, st_send} ins_state_type;

    ins_state_type state;
    logic [5:0] pos;
    logic [3:0] ch, dsg, ai, ci;
    logic [1:0] an;
    logic rpt;
    logic [7:0] sum_x, sum_y, s0;
    logic [3:0] last_ci [SERVICES];
    logic [SERVICES-1:0] ci_known;
    logic [7:0] col_x [USER_BYTES];
    logic [7:0] col_y [USER_BYTES];
    logic [9:0] svc;
    logic [5:0] col;
    logic [7:0] data_now, y_full, next_byte;
    logic protect_row;

    assign svc = service_index(req_channel, req_app_id, req_app_number);
    assign col = pos - POS_DATA_FIRST;
    assign protect_row = (ci == CI_PROTECT_P) || (ci == CI_PROTECT_Q);

    // payload or protection byte
    always_comb begin
        data_now = payload_byte;
        if (protect_row && col < 6'(USER_BYTES)) begin
            data_now = suffix_first(col_x[col], gf_mul2(gf_mul2(col_y[col])));
            if (ci == CI_PROTECT_Q) begin
                data_now = data_now ^ col_x[col];
            end
        end
    end

    assign y_full = gf_mul2(gf_mul2(sum_y));
    assign s0 = suffix_first(sum_x, y_full);

    // byte for the current position
    always_comb begin
        case (pos)
            POS_CHANNEL: next_byte = ham_encode(ch);
            POS_DESIGNATION: next_byte = ham_encode(dsg);
            POS_FORMAT: next_byte = ham_encode({an, 2'b01});
            POS_APP_ID: next_byte = ham_encode(ai);
            POS_CONTINUITY: next_byte = ham_encode(ci);
            POS_SUFFIX0: next_byte = s0;
            POS_SUFFIX1: next_byte = s0 ^ sum_x;
            default: next_byte = data_now;
        endcase
    end

    // packet sequencing
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= st_idle;
            pos <= POS_CHANNEL;
            busy <= 1'b0;
            link.line_valid <= 1'b0;
            link.line_start <= 1'b0;
            link.line_byte <= 8'h00;
            payload_take <= 1'b0;
        end else begin
            link.line_start <= 1'b0;
            payload_take <= 1'b0;
            case (state)
                st_idle: begin
                    link.line_valid <= 1'b0;
                    busy <= pkt_request;
                    if (pkt_request) begin
                        state <= st_send;
                        pos <= POS_CHANNEL;
                    end
                end
                st_send: begin
                    link.line_valid <= 1'b1;
                    link.line_start <= (pos == POS_CHANNEL);
                    link.line_byte <= next_byte;
                    pos <= pos + 6'h01;
                    payload_take <= (pos >= POS_CONTINUITY) && (pos < POS_DATA_LAST) && !protect_row;
                    if (pos == POS_SUFFIX1) begin
                        state <= st_idle;
                        busy <= 1'b0;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // continuity per service: advance on new packets, hold on repeats
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ci_known <= '0;
            ci <= 4'h0;
            ch <= 4'h0;
            dsg <= 4'h0;
            ai <= 4'h0;
            an <= 2'b00;
            rpt <= 1'b0;
        end else if (state == st_idle && pkt_request) begin
            ch <= req_channel;
            dsg <= req_designation;
            ai <= req_app_id;
            an <= req_app_number;
            rpt <= req_repeat;
            if (req_repeat && ci_known[svc]) begin
                ci <= last_ci[svc];
            end else begin
                ci <= ci_known[svc] ? last_ci[svc] + 4'h1 : 4'h0;
                last_ci[svc] <= ci_known[svc] ? last_ci[svc] + 4'h1 : 4'h0;
                ci_known[svc] <= 1'b1;
            end
        end
    end

    // row and column sums
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sum_x <= 8'h00;
            sum_y <= 8'h00;
        end else if (state == st_send) begin
            if (pos == POS_CONTINUITY) begin
                sum_x <= 8'h00;
                sum_y <= 8'h00;
            end else if (pos >= POS_DATA_FIRST && pos <= POS_DATA_LAST) begin
                sum_x <= sum_x ^ data_now;
                sum_y <= gf_mul2(sum_y) ^ data_now;
                if (!protect_row && !rpt) begin
                    col_x[col] <= (ci == 4'h0) ? data_now : col_x[col] ^ data_now;
                    col_y[col] <= (ci == 4'h0) ? data_now : gf_mul2(col_y[col]) ^ data_now;
                end
            end
        end
    end
endmodule

// ### rtl/idl_b_decoder.sv
// format b packet parser
// assumes line_valid marks each byte
//
// How it works
// - fields arrive in order, least bit first
// - header bytes hamming 8/4, rest plain bytes
// - byte 4 channel, byte 5 designation
// - format b when bit1 set, bit2 clear
// - bit1 clear is format a, both reserved
// - bits 4 and 3 give application number
// - byte 7 holds 4-bit application identifier
// - up to 64 services per channel tracked
// - sender steps continuity modulo 16 per service
// - sender never skips a continuity value
// - repeats keep the same continuity value
// - bytes 9 to 43 plain payload
// - bytes 44 and 45 are suffix bytes
// - suffix is single-symbol reed-solomon over payload
// - field of 256, element two, poly 11D
// - bundle of 16, rows 14 and 15 protection
// - both syndromes zero means error free
`timescale 1ns/1ps
module idl_b_decoder (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // link
    idl_link_if.decoder link,
    // header fields
    output logic [3:0] data_channel,
    output logic [3:0] designation,
    output idl_b_pkg::format_kind_type format_kind,
    output logic [1:0] app_number,
    output logic [3:0] app_id,
    output logic [3:0] continuity_index,
    output logic repeat_flag,
    output logic continuity_flag,
    output logic length_present_flag,
    output logic header_error,
    // payload bytes
    output logic [7:0] user_byte,
    output logic [5:0] user_index,
    output logic user_valid,
    output logic protection_byte,
    // packet summary
    output logic packet_done,
    output logic error_free,
    output logic [7:0] syndrome_x,
    output logic [7:0] syndrome_y,
    output logic lost_packet,
    output logic repeat_packet
);
    import idl_b_pkg::*;

    typedef enum {st_wait, st_packet} dec_state_type;

    dec_state_type state;
    logic [5:0] pos;
    logic [7:0] sum_x, sum_y;
    logic [4:0] ham;
    logic [3:0] last_ci [SERVICES];
    logic [SERVICES-1:0] ci_known;
    logic [9:0] svc;
    logic [3:0] stored;
    logic [7:0] next_x, next_y;
    logic [5:0] cur_pos;
    logic take;

    // a start byte always restarts the packet at byte 4
    assign take = link.line_valid;
    assign cur_pos = link.line_start ? POS_CHANNEL : pos;
    assign ham = ham_decode(link.line_byte);
    assign svc = service_index(data_channel, app_id, app_number);
    assign stored = last_ci[svc];
    assign next_x = sum_x ^ link.line_byte;
    assign next_y = gf_mul2(sum_y) ^ link.line_byte;

    // position tracking within the packet
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= st_wait;
            pos <= POS_CHANNEL;
        end else if (take) begin
            if (link.line_start || state == st_packet) begin
                state <= (cur_pos == POS_SUFFIX1) ? st_wait : st_packet;
                pos <= cur_pos + 6'h01;
            end
        end
    end

    // header fields
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_channel <= 4'h0;
            designation <= 4'h0;
            format_kind <= format_reserved;
            app_number <= 2'b00;
            app_id <= 4'h0;
            continuity_index <= 4'h0;
            repeat_flag <= 1'b0;
            continuity_flag <= 1'b0;
            length_present_flag <= 1'b0;
            header_error <= 1'b0;
        end else if (take && (link.line_start || state == st_packet)) begin
            case (cur_pos)
                POS_CHANNEL: begin
                    data_channel <= ham[3:0];
                    header_error <= ham[4];
                end
                POS_DESIGNATION: begin
                    designation <= ham[3:0];
                    header_error <= header_error | ham[4];
                end
                POS_FORMAT: begin
                    header_error <= header_error | ham[4];
                    repeat_flag <= 1'b0;
                    continuity_flag <= 1'b0;
                    length_present_flag <= 1'b0;
                    app_number <= 2'b00;
                    if (!ham[FT_FORMAT_BIT]) begin
                        format_kind <= format_a;
                        repeat_flag <= ham[FT_SECOND_BIT];
                        continuity_flag <= ham[FT_AN_LOW];
                        length_present_flag <= ham[FT_AN_HIGH];
                    end else if (!ham[FT_SECOND_BIT]) begin
                        format_kind <= format_b;
                        app_number <= {ham[FT_AN_HIGH], ham[FT_AN_LOW]};
                    end else begin
                        format_kind <= format_reserved;
                    end
                end
                POS_APP_ID: begin
                    app_id <= ham[3:0];
                    header_error <= header_error | ham[4];
                end
                POS_CONTINUITY: begin
                    continuity_index <= ham[3:0];
                    header_error <= header_error | ham[4];
                end
                default: begin
                    header_error <= header_error;
                end
            endcase
        end
    end

    // payload bytes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            user_byte <= 8'h00;
            user_index <= 6'h00;
            user_valid <= 1'b0;
            protection_byte <= 1'b0;
        end else begin
            user_valid <= 1'b0;
            if (take && state == st_packet && !link.line_start && pos >= POS_DATA_FIRST && pos <= POS_DATA_LAST) begin
                user_byte <= link.line_byte;
                user_index <= pos - POS_DATA_FIRST;
                user_valid <= 1'b1;
                protection_byte <= continuity_index >= CI_PROTECT_P;
            end
        end
    end

    // syndromes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sum_x <= 8'h00;
            sum_y <= 8'h00;
        end else if (take && (link.line_start || state == st_packet)) begin
            if (cur_pos < POS_DATA_FIRST) begin
                sum_x <= 8'h00;
                sum_y <= 8'h00;
            end else begin
                sum_x <= next_x;
                sum_y <= next_y;
            end
        end
    end

    // summary and continuity
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            packet_done <= 1'b0;
            error_free <= 1'b0;
            syndrome_x <= 8'h00;
            syndrome_y <= 8'h00;
            lost_packet <= 1'b0;
            repeat_packet <= 1'b0;
            ci_known <= '0;
        end else begin
            packet_done <= 1'b0;
            if (take && state == st_packet && !link.line_start && pos == POS_SUFFIX1) begin
                packet_done <= 1'b1;
                syndrome_x <= next_x;
                syndrome_y <= next_y;
                error_free <= (next_x == 8'h00) && (next_y == 8'h00);
                lost_packet <= 1'b0;
                repeat_packet <= 1'b0;
                if (format_kind == format_b && !header_error) begin
                    if (ci_known[svc]) begin
                        repeat_packet <= continuity_index == stored;
                        lost_packet <= (continuity_index != stored) && (continuity_index != stored + 4'h1);
                    end
                    last_ci[svc] <= continuity_index;
                    ci_known[svc] <= 1'b1;
                end
            end
        end
    end
endmodule

// ### test/idl_b_assertions.sv
// link checker
// assumes one inserter drives the link
`timescale 1ns/1ps
module idl_b_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // link
    input wire logic [7:0] line_byte,
    input wire logic line_valid,
    input wire logic line_start
);
    logic [5:0] pos;
    logic [5:0] pos_now;
    logic [7:0] sx;
    logic [7:0] sy;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // hamming parity
    function automatic logic ham_ok(input logic [7:0] b);
        return (b[0] ^ b[1] ^ b[5] ^ b[7]) & (b[2] ^ b[1] ^ b[3] ^ b[7]) & (b[4] ^ b[1] ^ b[3] ^ b[5]) & (^b);
    endfunction

    // position of current byte
    assign pos_now = line_start ? 6'h04 : pos;

    // position counter
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pos <= 6'h00;
        end else if (line_valid) begin
            pos <= pos_now + 6'h01;
        end
    end

    // running syndromes
    always_ff @(posedge ref_clk) begin
        if (reset || line_start) begin
            sx <= 8'h00;
            sy <= 8'h00;
        end else if (line_valid && pos_now >= 6'h09) begin
            sx <= sx ^ line_byte;
            sy <= {sy[6:0], 1'b0} ^ (sy[7] ? 8'h1D : 8'h00) ^ line_byte;
        end
    end

    start_valid_a: assert property (line_start |-> line_valid)
        else $error("lone start");
    start_pulse_a: assert property (line_start |=> !line_start)
        else $error("long start");
    frame_open_a: assert property ($rose(line_valid) |-> line_start)
        else $error("no start");
    frame_run_a: assert property (line_valid && pos_now < 6'h2D |=> line_valid && !line_start)
        else $error("packet cut");
    frame_gap_a: assert property (line_valid && pos_now == 6'h2D |=> !line_valid)
        else $error("no gap");
    frame_bound_a: assert property (line_valid |-> pos_now >= 6'h04 && pos_now <= 6'h2D)
        else $error("bad position");
    header_ham_a: assert property (line_valid && pos_now <= 6'h08 |-> ham_ok(line_byte))
        else $error("header not coded");
    format_b_a: assert property (line_valid && pos_now == 6'h06 |-> line_byte[1] && !line_byte[3])
        else $error("not format b");
    suffix_zero_a: assert property (line_valid && pos_now == 6'h2D |=> sx == 8'h00 && sy == 8'h00)
        else $error("syndrome not zero");
    reset_quiet_a: assert property (disable iff (1'b0) reset |=> !line_valid && !line_start)
        else $error("active in reset");

    cover property (line_start);
    cover property (line_valid && pos_now == 6'h06 && line_byte[7]);
    cover property (line_valid && pos_now == 6'h2D);
endmodule

// ### test/tb_top.sv
// bench: inserter to decoder, plus a second decoder fed raw lines, some with faults
// assumes package and interface compile first
`timescale 1ns/1ps
module tb_top;
    import idl_b_pkg::*;
    typedef struct packed {logic [3:0] ch, ds, ai; logic [1:0] an; logic rep; logic [3:0] ci;} case_type;
    logic ref_clk, reset, pkt_request, req_repeat, busy, payload_take;
    logic [3:0] req_channel, req_designation, req_app_id, data_channel, designation, app_id, continuity_index;
    logic [1:0] req_app_number, app_number;
    logic [7:0] payload_byte, seed, sx2;
    format_kind_type format_kind, fk2;
    logic header_error, packet_done, error_free, lost_packet, repeat_packet;
    logic rf2, cf2, lf2, he2, pd2, ef2, lp2, rp2;
    logic [7:0] cap [4:45];
    logic [7:0] row [$], col [$];
    logic [15:0] sfx;
    int error_cnt = 0, compares = 0, cycles = 0, pos = 0, takes = 0;
    case_type cases [7] = '{'{4'h1, 4'h2, 4'h3, 2'h0, 1'b0, 4'h0}, '{4'h1, 4'h2, 4'h3, 2'h0, 1'b0, 4'h1},
        '{4'h1, 4'h2, 4'h3, 2'h0, 1'b1, 4'h1}, '{4'h1, 4'h2, 4'h3, 2'h1, 1'b0, 4'h0},
        '{4'h1, 4'h2, 4'h3, 2'h0, 1'b0, 4'h2}, '{4'hF, 4'h9, 4'hF, 2'h3, 1'b0, 4'h0},
        '{4'h1, 4'h2, 4'h3, 2'h1, 1'b1, 4'h0}};

    idl_link_if link();
    idl_link_if link2();
    idl_b_inserter idl_b_inserter_inst (.ref_clk(ref_clk), .reset(reset), .pkt_request(pkt_request),
        .req_channel(req_channel), .req_designation(req_designation), .req_app_id(req_app_id),
        .req_app_number(req_app_number), .req_repeat(req_repeat), .busy(busy), .payload_byte(payload_byte),
        .payload_take(payload_take), .link(link));
    idl_b_decoder idl_b_decoder_inst (.ref_clk(ref_clk), .reset(reset), .link(link), .data_channel(data_channel),
        .designation(designation), .format_kind(format_kind), .app_number(app_number), .app_id(app_id),
        .continuity_index(continuity_index), .repeat_flag(), .continuity_flag(), .length_present_flag(),
        .header_error(header_error), .user_byte(), .user_index(), .user_valid(), .protection_byte(),
        .packet_done(packet_done), .error_free(error_free), .syndrome_x(), .syndrome_y(),
        .lost_packet(lost_packet), .repeat_packet(repeat_packet));
    idl_b_decoder idl_b_decoder_inst2 (.ref_clk(ref_clk), .reset(reset), .link(link2), .data_channel(),
        .designation(), .format_kind(fk2), .app_number(), .app_id(), .continuity_index(), .repeat_flag(rf2),
        .continuity_flag(cf2), .length_present_flag(lf2), .header_error(he2), .user_byte(), .user_index(),
        .user_valid(), .protection_byte(), .packet_done(pd2), .error_free(ef2), .syndrome_x(sx2),
        .syndrome_y(), .lost_packet(lp2), .repeat_packet(rp2));
    idl_b_assertions idl_b_assertions_inst (.ref_clk(ref_clk), .reset(reset), .line_byte(link.line_byte),
        .line_valid(link.line_valid), .line_start(link.line_start));

    function automatic logic [7:0] mul2(input logic [7:0] v);
        return {v[6:0], 1'b0} ^ (v[7] ? 8'h1D : 8'h00);
    endfunction
    function automatic logic [7:0] ham(input logic [3:0] m);
        logic p1, p2, p3;
        p1 = ~(m[0] ^ m[2] ^ m[3]);
        p2 = ~(m[0] ^ m[1] ^ m[3]);
        p3 = ~(m[0] ^ m[1] ^ m[2]);
        return {m[3], ~(p1 ^ p2 ^ p3 ^ (^m)), m[2], p3, m[1], p2, m[0], p1};
    endfunction
    function automatic logic [7:0] pat(input logic [7:0] s, input int k);
        return s + 8'(k * 11);
    endfunction
    // returns {s1, s0}
    function automatic logic [15:0] rs_pair(input logic [7:0] d [$]);
        logic [7:0] x, y, s0;
        x = 8'h00;
        y = 8'h00;
        s0 = 8'h00;
        foreach (d[i]) begin
            x = x ^ d[i];
            y = mul2(y) ^ d[i];
        end
        y = mul2(mul2(y));
        for (int v = 0; v < 256; v++) begin
            if ((mul2(8'(v)) ^ 8'(v)) == (x ^ y)) begin
                s0 = 8'(v);
            end
        end
        return {s0 ^ x, s0};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic fill_row(input logic [7:0] s);
        row.delete();
        for (int k = 0; k < 35; k++) begin
            row.push_back(pat(s, k));
        end
    endtask
    // call just after an edge
    task automatic wait_done(input logic second);
        for (int i = 0; i < 200; i++) begin
            #1;
            if (second ? pd2 : packet_done) begin
                return;
            end
            @(posedge ref_clk);
        end
        check("packet_done", 16'h0000, 16'h0001);
    endtask
    // one packet, then all fields compared
    task automatic pkt(input logic [3:0] ch, ds, ai, input logic [1:0] an, input logic rep,
                       input logic [7:0] s, input logic [3:0] ci);
        @(posedge ref_clk);
        pkt_request <= 1'b1;
        {req_channel, req_designation, req_app_id, req_app_number, req_repeat} <= {ch, ds, ai, an, rep};
        takes <= 0;
        seed <= s;
        payload_byte <= pat(s, 0);
        @(posedge ref_clk);
        pkt_request <= 1'b0;
        wait_done(1'b0);
        if (ci < 4'hE) begin
            fill_row(s);
        end
        check("hdr_ch_ds", {cap[4], cap[5]}, {ham(ch), ham(ds)});
        check("hdr_ft_ai", {cap[6], cap[7]}, {ham({an, 2'b01}), ham(ai)});
        check("ci", {cap[8], 4'h0, continuity_index}, {ham(ci), 4'h0, ci});
        check("fields", {data_channel, designation, app_id, app_number, format_kind}, {ch, ds, ai, an, format_b});
        check("status", 16'({header_error, error_free, lost_packet, repeat_packet}), 16'({3'b010, rep}));
        check("takes", 16'(takes), ci < 4'hE ? 16'h0023 : 16'h0000);
        for (int k = 0; k < 35; k++) begin
            check("payload", 16'(cap[9 + k]), 16'(row[k]));
        end
        check("suffix", {cap[45], cap[44]}, rs_pair(row));
    endtask
    // raw packet on link2 with optional faults
    task automatic send_raw(input logic [3:0] ft, ci, input logic [7:0] flip, hflip);
        logic [7:0] b [4:45];
        fill_row(8'hA5);
        sfx = rs_pair(row);
        b[4] = ham(4'h5);
        b[5] = ham(4'h1);
        b[6] = ham(ft);
        b[7] = ham(4'h1) ^ hflip;
        b[8] = ham(ci);
        for (int k = 0; k < 35; k++) begin
            b[9 + k] = row[k];
        end
        b[14] = b[14] ^ flip;
        {b[45], b[44]} = sfx;
        for (int p = 4; p < 46; p++) begin
            @(posedge ref_clk);
            link2.line_valid <= 1'b1;
            link2.line_start <= (p == 4);
            link2.line_byte <= b[p];
        end
        @(posedge ref_clk);
        link2.line_valid <= 1'b0;
        link2.line_start <= 1'b0;
        link2.line_byte <= ~b[45];
        wait_done(1'b1);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // capture, payload supply, timeout
    always @(posedge ref_clk) begin
        cycles++;
        if (link.line_valid) begin
            pos = link.line_start ? 4 : pos;
            cap[pos] <= link.line_byte;
            pos = pos + 1;
        end
        if (payload_take) begin
            takes <= takes + 1;
            payload_byte <= pat(seed, takes + 1);
        end
        if (cycles == 4000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        reset = 1'b1;
        pkt_request = 1'b0;
        {req_channel, req_designation, req_app_id, req_app_number, req_repeat} = 15'h0000;
        payload_byte = 8'h00;
        {link2.line_valid, link2.line_start, link2.line_byte} = 10'h000;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (cases[i]) begin
            pkt(cases[i].ch, cases[i].ds, cases[i].ai, cases[i].an, cases[i].rep, 8'(i * 23 + 1), cases[i].ci);
        end
        $display("service table done");
        // reset in the middle of a packet
        @(posedge ref_clk);
        pkt_request <= 1'b1;
        @(posedge ref_clk);
        pkt_request <= 1'b0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check("reset_out", {busy, payload_take, link.line_valid, continuity_index, data_channel, packet_done,
              error_free, format_kind, 1'b0}, {13'h0000, format_reserved, 1'b0});
        @(posedge ref_clk);
        reset <= 1'b0;
        $display("reset done");
        // bundle and index wrap
        for (int r = 0; r < 17; r++) begin
            if (r == 14 || r == 15) begin
                row.delete();
                for (int c = 0; c < 35; c++) begin
                    col.delete();
                    for (int j = 0; j < 14; j++) begin
                        col.push_back(pat(8'(8'h40 + j), c));
                    end
                    sfx = rs_pair(col);
                    row.push_back(r == 14 ? sfx[7:0] : sfx[15:8]);
                end
            end
            pkt(4'h1, 4'h2, 4'h3, 2'h0, 1'b0, 8'(8'h40 + r), 4'(r));
        end
        $display("bundle done");
        send_raw(4'h1, 4'h0, 8'h00, 8'h00);
        send_raw(4'h1, 4'h2, 8'h00, 8'h00);
        check("gap", 16'({lp2, rp2, ef2}), 16'h0005);
        send_raw(4'h1, 4'h2, 8'h00, 8'h00);
        check("repeat", 16'({lp2, rp2, ef2}), 16'h0003);
        send_raw(4'h1, 4'h3, 8'h40, 8'h00);
        check("bad_byte", 16'({lp2, ef2, sx2}), 16'h0040);
        send_raw(4'hA, 4'h0, 8'h00, 8'h00);
        check("format_a", 16'({fk2, rf2, cf2, lf2, he2}), 16'({format_a, 4'b1010}));
        send_raw(4'h3, 4'h0, 8'h00, 8'h00);
        check("reserved", 16'(fk2), 16'(format_reserved));
        send_raw(4'h1, 4'h9, 8'h00, 8'h01);
        check("hdr_fault", 16'({he2, lp2}), 16'h0002);
        $display("raw cases done");
        results();
    end
endmodule
